// ---- design/scs_pkg.sv ----
// Shared constants, types and decode helpers of the system clock select block
package scs_pkg;

   // =====================================================================
   // Register map (index = word number, byte address = index * 4)
   // =====================================================================
   localparam int           ADDR_W       = 12;       // APB address bits decoded
   localparam logic [9:0]   CRYSTAL_IDX  = 10'h00a;  // Crystal oscillator control
   localparam logic [9:0]   CLKMODE_IDX  = 10'h00b;  // Clock mode
   localparam logic [9:0]   STATUS_IDX   = 10'h00c;  // Switch status, read only
   localparam logic [11:0]  CRYSTAL_ADDR = {CRYSTAL_IDX, 2'b00};
   localparam logic [11:0]  CLKMODE_ADDR = {CLKMODE_IDX, 2'b00};
   localparam logic [11:0]  STATUS_ADDR  = {STATUS_IDX, 2'b00};

   // =====================================================================
   // Field positions
   // =====================================================================
   localparam int XTAL_EN_BIT   = 7;  // Crystal oscillator enable
   localparam int DRIVE_MSB     = 6;  // Crystal drive field, upper bit
   localparam int DRIVE_LSB     = 5;  // Crystal drive field, lower bit
   localparam int FAST_EN_BIT   = 4;  // Fast RC enable
   localparam int SLOW_EN_BIT   = 2;  // Slow RC enable
   localparam int WDT_EN_BIT    = 1;  // Watchdog enable

   // Drive codes
   localparam logic [1:0] DRIVE_LOW  = 2'h1;
   localparam logic [1:0] DRIVE_MID  = 2'h2;
   localparam logic [1:0] DRIVE_HIGH = 2'h3;

   // =====================================================================
   // Reset values
   // =====================================================================
   localparam logic [7:0] CLKMODE_DIV16  = 8'h1c;  // Fast RC / 16
   localparam logic [7:0] CLKMODE_DIV32  = 8'h7c;  // Fast RC / 32
   localparam logic [7:0] CLKMODE_SLOW   = 8'he4;  // Slow RC, fast RC off
   localparam logic [7:0] BOOT_SLOW      = 8'he6;  // Uncalibrated, slow RC, watchdog on
   localparam logic [7:0] BOOT_FAST64    = 8'h5e;  // Uncalibrated, fast RC / 64
   localparam logic [7:0] CRYSTAL_RESET  = 8'h00;  // Crystal off

   // =====================================================================
   // Source/divider codes taken from clock mode bits {7:5,3}
   // =====================================================================
   localparam logic [3:0] SEL_FAST_DIV2  = 4'h2;
   localparam logic [3:0] SEL_FAST_DIV4  = 4'h0;
   localparam logic [3:0] SEL_FAST_DIV8  = 4'h3;
   localparam logic [3:0] SEL_FAST_DIV16 = 4'h1;
   localparam logic [3:0] SEL_FAST_DIV32 = 4'h7;
   localparam logic [3:0] SEL_FAST_DIV64 = 4'h5;
   localparam logic [3:0] SEL_SLOW       = 4'he;
   localparam logic [3:0] SEL_XTAL       = 4'ha;

   // =====================================================================
   // Types
   // =====================================================================
   typedef enum logic [1:0] {
      CAL_DIV16 = 2'h0,  // Calibrated, fast RC / 16
      CAL_DIV32 = 2'h1,  // Calibrated, fast RC / 32
      CAL_SLOW  = 2'h2,  // Calibrated, slow RC
      CAL_OFF   = 2'h3   // Not calibrated
   } scs_cal_t;

   typedef enum logic [2:0] {
      SRC_FAST = 3'b001,
      SRC_SLOW = 3'b010,
      SRC_XTAL = 3'b100
   } scs_src_t;

   typedef enum logic [1:0] {
      FSM_RUN  = 2'b01,  // Ticking from the active source
      FSM_WAIT = 2'b10   // Waiting for an edge of the new source
   } scs_fsm_t;

   typedef struct packed {
      scs_src_t   src;       // Selected source
      logic [2:0] div_log2;  // Division as a power of two
   } scs_sel_t;

   typedef struct packed {
      logic [ADDR_W-1:0] paddr;
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [31:0]       pwdata;
   } scs_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } scs_apb_rsp_t;

   typedef struct packed {
      logic       fast_rc_en;
      logic       slow_rc_en;
      logic       crystal_en;
      logic [1:0] crystal_drive;
      logic       watchdog_en;
   } scs_osc_ctrl_t;

   // Clock mode byte to source and divider
   function automatic scs_sel_t decode_mode(input logic [7:0] m);
      scs_sel_t s;
      s = '{src: SRC_SLOW, div_log2: 3'h0};
      case ({m[7:5], m[3]})
         SEL_FAST_DIV2:  s = '{src: SRC_FAST, div_log2: 3'h1};
         SEL_FAST_DIV4:  s = '{src: SRC_FAST, div_log2: 3'h2};
         SEL_FAST_DIV8:  s = '{src: SRC_FAST, div_log2: 3'h3};
         SEL_FAST_DIV16: s = '{src: SRC_FAST, div_log2: 3'h4};
         SEL_FAST_DIV32: s = '{src: SRC_FAST, div_log2: 3'h5};
         SEL_FAST_DIV64: s = '{src: SRC_FAST, div_log2: 3'h6};
         SEL_XTAL:       s = '{src: SRC_XTAL, div_log2: 3'h0};
         default:        s = '{src: SRC_SLOW, div_log2: 3'h0};
      endcase
      return s;
   endfunction

   // Boot value of the clock mode register for a build option
   function automatic logic [7:0] boot_mode(input scs_cal_t cal, input logic fast64);
      logic [7:0] v;
      v = fast64 ? BOOT_FAST64 : BOOT_SLOW;
      case (cal)
         CAL_DIV16: v = CLKMODE_DIV16;
         CAL_DIV32: v = CLKMODE_DIV32;
         CAL_SLOW:  v = CLKMODE_SLOW;
         default:   v = fast64 ? BOOT_FAST64 : BOOT_SLOW;
      endcase
      return v;
   endfunction

endpackage

// ---- design/scs_sync.sv ----
// Two-flop synchroniser for oscillator levels entering the system clock
`timescale 1ns/10ps
module scs_sync #(
   parameter int W = 3  // Number of levels
) (
   input  wire logic         clk_sys_i,
   input  wire logic         reset_n_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   import scs_pkg::*;

   // =====================================================================
   // State
   // =====================================================================
   typedef struct packed {
      logic [W-1:0] meta;  // First stage, read only by the second
      logic [W-1:0] hold;  // Second stage
   } scs_sync_st_t;

   scs_sync_st_t st;
   scs_sync_st_t next_st;

   // Shift one stage per cycle
   always_comb begin
      next_st      = st;
      next_st.meta = async_i;
      next_st.hold = st.meta;
   end

   // Register state
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_o = st.hold;
endmodule

// ---- design/scs_edge_div.sv ----
// Power-of-two divider of source edges into system clock enable ticks
`timescale 1ns/10ps
module scs_edge_div (
   input  wire logic       clk_sys_i,
   input  wire logic       reset_n_i,
   input  wire logic       edge_i,      // Rising edge of the active source
   input  wire logic       restart_i,   // Clear the count on a switch
   input  wire logic [2:0] div_log2_i,  // Division as power of two
   output logic            tick_o       // One-cycle system clock enable
);
   import scs_pkg::*;

   // =====================================================================
   // State
   // =====================================================================
   typedef struct packed {
      logic [5:0] cnt;   // Edges seen since last tick
      logic       tick;  // Registered tick
   } scs_div_st_t;

   scs_div_st_t st;
   scs_div_st_t next_st;
   logic [5:0]  limit;  // Last count before a tick

   // Count edges, tick at the limit
   always_comb begin
      next_st      = st;
      next_st.tick = 1'b0;
      limit        = 6'((7'h01 << div_log2_i) - 7'h01);
      if (restart_i) begin
         next_st.cnt = 6'h00;
      end else if (edge_i) begin
         if (st.cnt >= limit) begin
            next_st.cnt  = 6'h00;
            next_st.tick = 1'b1;
         end else begin
            next_st.cnt = st.cnt + 6'h01;
         end
      end
   end

   // Register state
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick_o = st.tick;
endmodule

// ---- design/scs_clock_ctrl.sv ----
// System clock source select, oscillator enables and APB register slave
`timescale 1ns/10ps
module scs_clock_ctrl #(
   parameter scs_pkg::scs_cal_t CAL_OPT     = scs_pkg::CAL_DIV16,  // Build option
   parameter logic              BOOT_FAST64 = 1'b0  // Uncalibrated boot on fast RC / 64
) (
   input  wire logic                 clk_sys_i,
   input  wire logic                 reset_n_i,
   input  wire scs_pkg::scs_apb_req_t apb_req_i,       // APB request
   output scs_pkg::scs_apb_rsp_t      apb_rsp_o,       // APB answer
   input  wire logic                 fast_rc_clk_i,   // Fast RC oscillator output
   input  wire logic                 slow_rc_clk_i,   // Slow RC oscillator output
   input  wire logic                 crystal_pin_in_i, // Shaped crystal oscillator output
   output scs_pkg::scs_osc_ctrl_t     osc_ctrl_o,      // Oscillator enables and drive
   output logic                      sys_clk_en_o,    // System clock enable tick
   output scs_pkg::scs_src_t          active_src_o     // Source now clocking the system
);
   import scs_pkg::*;

   // =====================================================================
   // Constants
   // =====================================================================
   localparam logic [7:0] BOOT_MODE = boot_mode(CAL_OPT, BOOT_FAST64);  // Reset mode
   localparam logic [1:0] DEC_NONE  = 2'h0;  // Unmapped address
   localparam logic [1:0] DEC_XTAL  = 2'h1;  // Crystal control
   localparam logic [1:0] DEC_MODE  = 2'h2;  // Clock mode
   localparam logic [1:0] DEC_STAT  = 2'h3;  // Status

   // Address decode, shared by read and write paths
   function automatic logic [1:0] addr_dec(input logic [ADDR_W-1:0] a);
      logic [1:0] d;
      d = DEC_NONE;
      if (a == CRYSTAL_ADDR) begin
         d = DEC_XTAL;
      end else if (a == CLKMODE_ADDR) begin
         d = DEC_MODE;
      end else if (a == STATUS_ADDR) begin
         d = DEC_STAT;
      end else begin
         d = DEC_NONE;
      end
      return d;
   endfunction

   // =====================================================================
   // State
   // =====================================================================
   typedef struct packed {
      logic [7:0]  mode;     // Clock mode register
      logic [7:0]  xtal;     // Crystal control register
      scs_fsm_t    fsm;      // Switch sequencer
      scs_sel_t    act;      // Source and divider in use
      logic [2:0]  prev;     // Previous synced oscillator levels
      logic        restart;  // Divider restart pulse
      logic        wrote;    // Mode written since reset
      logic [31:0] prdata;   // Read data, captured in setup
      logic        pslverr;  // Error, captured in setup
   } scs_st_t;

   scs_st_t     st;
   scs_st_t     next_st;
   logic [2:0]  osc_sync;   // Synced oscillator levels {xtal, slow, fast}
   logic [2:0]  osc_rise;   // Rising edges of each oscillator
   logic        src_edge;   // Edge of the active source
   logic        new_edge;   // Edge of the pending source
   logic        div_tick;   // Divider output
   logic        setup;      // APB setup cycle
   logic        wr_acc;     // APB write access
   logic [1:0]  dec;        // Decoded address
   scs_sel_t    want;       // Selection from the mode register

   // =====================================================================
   // Oscillator crossing and edge detection
   // =====================================================================
   scs_sync #(
      .W (3)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .async_i   ({crystal_pin_in_i, slow_rc_clk_i, fast_rc_clk_i}),
      .sync_o    (osc_sync)
   );

   // Per-source edges and selection
   always_comb begin
      osc_rise = osc_sync & ~st.prev;
      want     = decode_mode(st.mode);
      src_edge = |(osc_rise & st.act.src);
      new_edge = |(osc_rise & want.src);
   end

   // Divider gated while a switch waits, so no runt tick appears
   scs_edge_div u_div (
      .clk_sys_i  (clk_sys_i),
      .reset_n_i  (reset_n_i),
      .edge_i     (src_edge && (st.fsm == FSM_RUN)),
      .restart_i  (st.restart),
      .div_log2_i (st.act.div_log2),
      .tick_o     (div_tick)
   );

   // =====================================================================
   // APB slave and switch sequencer
   // =====================================================================
   always_comb begin
      setup   = apb_req_i.psel && !apb_req_i.penable;
      wr_acc  = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;
      dec     = addr_dec(apb_req_i.paddr);
      next_st = st;
      next_st.prev    = osc_sync;
      next_st.restart = 1'b0;
      // Capture read data and error in setup, answered with no wait
      if (setup) begin
         next_st.pslverr = (dec == DEC_NONE) || (apb_req_i.pwrite && dec == DEC_STAT);
         if (dec == DEC_XTAL) begin
            next_st.prdata = {24'h000000, st.xtal};
         end else if (dec == DEC_MODE) begin
            next_st.prdata = {24'h000000, st.mode};
         end else if (dec == DEC_STAT) begin
            next_st.prdata = {26'h0000000, st.fsm == FSM_WAIT, st.act.src,
                              st.act.div_log2[1:0] == 2'h0 && st.act.div_log2[2] == 1'b0};
         end else begin
            next_st.prdata = 32'h00000000;
         end
      end
      // Switch sequencer
      case (st.fsm)
         FSM_RUN: begin
            next_st.fsm = FSM_RUN;
         end
         FSM_WAIT: begin
            // Take over at a full edge of the new source
            if (new_edge) begin
               next_st.act     = want;
               next_st.restart = 1'b1;
               next_st.fsm     = FSM_RUN;
            end
         end
         default: begin
            next_st.fsm = FSM_RUN;
         end
      endcase
      // Register writes, accepted at any time
      if (wr_acc && dec == DEC_XTAL) begin
         next_st.xtal = apb_req_i.pwdata[7:0];
      end else if (wr_acc && dec == DEC_MODE) begin
         next_st.mode  = apb_req_i.pwdata[7:0];
         next_st.wrote = 1'b1;
         next_st.fsm   = FSM_WAIT;
      end
   end

   // Register state, boot value set by the build option
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st         <= '0;
         st.mode    <= BOOT_MODE;
         st.xtal    <= CRYSTAL_RESET;
         st.fsm     <= FSM_RUN;
         st.act     <= decode_mode(BOOT_MODE);
      end else begin
         st <= next_st;
      end
   end

   // =====================================================================
   // Outputs
   // =====================================================================
   assign apb_rsp_o.prdata  = st.prdata;
   assign apb_rsp_o.pready  = 1'b1;
   assign apb_rsp_o.pslverr = st.pslverr;
   assign osc_ctrl_o.fast_rc_en    = st.mode[FAST_EN_BIT];
   assign osc_ctrl_o.slow_rc_en    = st.mode[SLOW_EN_BIT];
   assign osc_ctrl_o.watchdog_en   = st.mode[WDT_EN_BIT];
   assign osc_ctrl_o.crystal_en    = st.xtal[XTAL_EN_BIT];
   assign osc_ctrl_o.crystal_drive = st.xtal[DRIVE_MSB:DRIVE_LSB];
   assign sys_clk_en_o = div_tick;
   assign active_src_o = st.act.src;

   // =====================================================================
   // Assertions
   // =====================================================================
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_mode_wr(logic [7:0] v);
      wr_acc && dec == DEC_MODE && apb_req_i.pwdata[7:0] == v;
   endsequence

   sequence s_xtal_wr;
      wr_acc && dec == DEC_XTAL;
   endsequence

   // Pending switch takes over at this edge, no new write retargets it
   sequence s_switch_done;
      st.fsm == FSM_WAIT && new_edge && !wr_acc;
   endsequence

   AST_BOOT_MODE: assert property (!st.wrote |-> st.mode == BOOT_MODE)
      else $error("Clock mode left boot value without a write");
   AST_BOOT_WDT: assert property (!st.wrote && CAL_OPT != CAL_OFF |->
      !osc_ctrl_o.watchdog_en && osc_ctrl_o.slow_rc_en)
      else $error("Calibrated boot must have watchdog off and slow RC on");
   AST_XTAL_EN: assert property (s_xtal_wr |=>
      osc_ctrl_o.crystal_en == $past(apb_req_i.pwdata[XTAL_EN_BIT]))
      else $error("Crystal enable does not follow bit 7");
   AST_DRIVE: assert property (s_xtal_wr |=>
      osc_ctrl_o.crystal_drive == $past(apb_req_i.pwdata[DRIVE_MSB:DRIVE_LSB]))
      else $error("Crystal drive does not follow bits 6:5");
   AST_RC_EN: assert property (wr_acc && dec == DEC_MODE |=>
      osc_ctrl_o.fast_rc_en == $past(apb_req_i.pwdata[FAST_EN_BIT]) &&
      osc_ctrl_o.slow_rc_en == $past(apb_req_i.pwdata[SLOW_EN_BIT]))
      else $error("RC enables do not follow bits 4 and 2");
   AST_WR_PEND: assert property (wr_acc && dec == DEC_MODE |=> st.fsm == FSM_WAIT)
      else $error("Mode write did not start a switch");
   AST_TO_FAST2: assert property (s_switch_done ##0 st.mode == 8'h34 |=>
      st.act.src == SRC_FAST && st.act.div_log2 == 3'h1 && osc_ctrl_o.slow_rc_en)
      else $error("0x34 did not give fast RC / 2 with slow RC on");
   AST_TO_XTAL: assert property (s_switch_done ##0 (st.mode == 8'ha6 ||
      st.mode == 8'hb0 || st.mode == 8'hb4) |=> st.act.src == SRC_XTAL)
      else $error("Crystal select codes did not select the crystal");
   AST_TO_SLOW: assert property (s_mode_wr(8'hf4) |=> osc_ctrl_o.fast_rc_en &&
      want.src == SRC_SLOW)
      else $error("0xF4 must select slow RC and keep fast RC on");
   AST_TO_FAST4: assert property (s_mode_wr(8'h14) |=> want.src == SRC_FAST &&
      want.div_log2 == 3'h2)
      else $error("0x14 did not select fast RC / 4");
   AST_SWITCH_EDGE: assert property (st.fsm == FSM_WAIT && new_edge && !wr_acc |=>
      st.fsm == FSM_RUN && st.restart ##1 !sys_clk_en_o)
      else $error("Switch did not complete on the new source edge");
   AST_NO_RUNT: assert property (sys_clk_en_o |=> !sys_clk_en_o)
      else $error("Back-to-back system clock ticks");
endmodule

// ---- bench/scs_osc_model.sv ----
// Behavioural oscillators standing outside the clock select block
`timescale 1ns/10ps
module scs_osc_model (
   input  wire scs_pkg::scs_osc_ctrl_t ctrl_i, // Oscillator enables and drive
   output logic                        fast_o, // Fast RC wave, 20 ns period
   output logic                        slow_o, // Slow RC wave, 80 ns period
   output logic                        xtal_o  // Crystal wave, 40 ns period
);
   import scs_pkg::*;
   // =====================================================================
   // Oscillators: each toggles only while enabled, else rests low
   // =====================================================================
   initial begin
      fast_o = 1'h0;
      slow_o = 1'h0;
      xtal_o = 1'h0;
   end
   always #10 fast_o = ctrl_i.fast_rc_en ? ~fast_o : 1'h0;
   always #40 slow_o = ctrl_i.slow_rc_en ? ~slow_o : 1'h0;
   // Crystal needs its enable and a nonzero drive code to swing
   always #20 xtal_o = (ctrl_i.crystal_en && ctrl_i.crystal_drive != 2'h0) ? ~xtal_o : 1'h0;
endmodule

// ---- bench/tb_system_clock_select_control.sv ----
// Self-checking bench of the system clock select block
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
   $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module tb_system_clock_select_control;
   import scs_pkg::*;
   // =====================================================================
   // Signals
   // =====================================================================
   logic          clk_sys_i = 1'h0; // 200 MHz clock
   logic          reset_n_i = 1'h0; // Reset, active low
   scs_apb_req_t  req = '0;         // APB request
   scs_apb_rsp_t  rsp;              // APB answer
   scs_osc_ctrl_t osc;              // Oscillator controls
   scs_src_t      src;              // Active source
   logic          tick;             // System clock enable
   logic          fast;             // Fast RC wave
   logic          slow;             // Slow RC wave
   logic          xtal;             // Crystal wave
   logic [31:0]   rd;               // Last read data
   logic          err;              // Last slave error
   int            fails = 0;        // Mismatches
   int            n_checks = 0;     // Comparisons
   int            gap;              // Cycles between ticks
   always #2.5 clk_sys_i = ~clk_sys_i;
   scs_clock_ctrl dut (
      .clk_sys_i        (clk_sys_i),
      .reset_n_i        (reset_n_i),
      .apb_req_i        (req),
      .apb_rsp_o        (rsp),
      .fast_rc_clk_i    (fast),
      .slow_rc_clk_i    (slow),
      .crystal_pin_in_i (xtal),
      .osc_ctrl_o       (osc),
      .sys_clk_en_o     (tick),
      .active_src_o     (src)
   );
   scs_osc_model osc_model (
      .ctrl_i (osc),
      .fast_o (fast),
      .slow_o (slow),
      .xtal_o (xtal)
   );
   // =====================================================================
   // Tasks
   // =====================================================================
   // Verdict and end of run
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // One APB transfer, held until pready, then one idle edge
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      int k;
      req <= '{paddr: a, psel: 1'h1, penable: 1'h0, pwrite: w, pwdata: d};
      @(posedge clk_sys_i);
      req.penable <= 1'h1;
      k = 0;
      do begin
         @(posedge clk_sys_i);
         k++;
      end while (rsp.pready !== 1'h1 && k < 50);
      rd = rsp.prdata;
      err = rsp.pslverr;
      if (rsp.pready !== 1'h1) begin
         fails++;
         close_out();
      end
      req.psel <= 1'h0;
      req.penable <= 1'h0;
      @(posedge clk_sys_i);
   endtask
   // Cycles since the previous edge up to the next tick
   task automatic wait_tick();
      int k;
      k = 0;
      do begin
         @(posedge clk_sys_i);
         k++;
      end while (tick !== 1'h1 && k < 1000);
      if (tick !== 1'h1) begin
         fails++;
         close_out();
      end
      gap = k;
   endtask
   // Write a clock mode, wait for the switch, check enables and tick rate
   task automatic step(input logic [7:0] m, input scs_src_t s, input logic [1:0] en,
                       input int g);
      int k;
      xfer(CLKMODE_ADDR, 1'h1, {24'h0, m});
      xfer(CLKMODE_ADDR, 1'h0, 32'h0);
      `CHK(rd, {24'h0, m})
      k = 0;
      while (src !== s && k < 1000) begin
         @(posedge clk_sys_i);
         k++;
      end
      `CHK(src, s)
      `CHK({osc.fast_rc_en, osc.slow_rc_en}, en)
      wait_tick();
      wait_tick();
      `CHK(gap, g)
   endtask
   // =====================================================================
   // Main sequence
   // =====================================================================
   initial begin
      repeat (12) @(posedge clk_sys_i);
      reset_n_i <= 1'h1;
      @(posedge clk_sys_i);
      // Boot state of the divide-by-16 build
      xfer(CLKMODE_ADDR, 1'h0, 32'h0);
      `CHK(rd, 32'h1c)
      `CHK({osc.fast_rc_en, osc.slow_rc_en, osc.watchdog_en}, 3'h6)
      `CHK(src, SRC_FAST)
      wait_tick();
      wait_tick();
      `CHK(gap, 64)
      xfer(CRYSTAL_ADDR, 1'h0, 32'h0);
      `CHK(rd, 32'h0)
      // Unmapped address is refused
      xfer(12'h000, 1'h0, 32'h0);
      `CHK({err, rd}, {1'h1, 32'h0})
      // Every nonzero drive code with the crystal enabled
      for (int d = 1; d < 4; d++) begin
         xfer(CRYSTAL_ADDR, 1'h1, {24'h0, 1'h1, d[1:0], 5'h0});
         `CHK(osc.crystal_en, 1'h1)
         `CHK(osc.crystal_drive, d[1:0])
      end
      // Scaled stability wait on the crystal before selecting it
      repeat (512) @(posedge clk_sys_i);
      step(8'hf4, SRC_SLOW, 2'h3, 16);
      step(8'h34, SRC_FAST, 2'h3, 8);
      step(8'h14, SRC_FAST, 2'h3, 16);
      step(8'h34, SRC_FAST, 2'h3, 8);
      step(8'hb0, SRC_XTAL, 2'h2, 8);
      step(8'hb4, SRC_XTAL, 2'h3, 8);
      step(8'ha4, SRC_XTAL, 2'h1, 8);
      step(8'he4, SRC_SLOW, 2'h1, 16);
      step(8'ha6, SRC_XTAL, 2'h1, 8);
      `CHK(osc.watchdog_en, 1'h1)
      step(8'he4, SRC_SLOW, 2'h1, 16);
      // Crystal fully off before power-down
      xfer(CRYSTAL_ADDR, 1'h1, 32'h0);
      `CHK(osc.crystal_en, 1'h0)
      close_out();
   end
endmodule
